// *** fb_state_pkg.sv ***
// Purpose: Shared constants and types for the slave communication state control.
// Assumes: One system clock and one synchronous active-high reset.
// Notes: The enumerations below are the codes seen on the block's ports.
package fb_state_pkg;

    // Communication states in upward order.
    typedef enum logic [1:0] {
        st_power_up      = 2'h0,
        st_mailbox_cfg   = 2'h1,
        st_inputs_only   = 2'h2,
        st_full_exchange = 2'h3
    } comm_state_t;

    // Mailbox application protocols.
    typedef enum logic [1:0] {
        can_app_over_fieldbus       = 2'h0,
        servo_profile_over_fieldbus = 2'h1,
        ethernet_tunnelling         = 2'h2,
        file_transfer_protocol      = 2'h3
    } mbx_proto_t;

    // Motion operating modes.
    typedef enum logic [2:0] {
        profile_position_mode      = 3'h0,
        profile_velocity_mode      = 3'h1,
        profile_torque_mode        = 3'h2,
        interpolated_position_mode = 3'h3,
        homing_mode                = 3'h4,
        cyclic_sync_position_mode  = 3'h5,
        cyclic_sync_velocity_mode  = 3'h6,
        cyclic_sync_torque_mode    = 3'h7
    } op_mode_t;

    // Mapping index ranges and the maps actually offered.
    localparam logic [15:0] rx_map_lo       = 16'h1600;
    localparam logic [15:0] rx_map_hi       = 16'h17ff;
    localparam logic [15:0] tx_map_lo       = 16'h1a00;
    localparam logic [15:0] tx_map_hi       = 16'h1bff;
    localparam logic [15:0] rx_map_variable = 16'h1600;
    localparam logic [15:0] rx_fixed_first  = 16'h1701;
    localparam logic [15:0] rx_fixed_last   = 16'h1705;
    localparam logic [15:0] tx_map_variable = 16'h1a00;
    localparam logic [15:0] tx_fixed_first  = 16'h1b01;
    localparam logic [15:0] tx_fixed_last   = 16'h1b04;

    // Reset values.
    localparam comm_state_t state_reset  = st_power_up;
    localparam logic [15:0] rx_map_reset = rx_map_variable;
    localparam logic [15:0] tx_map_reset = tx_map_variable;
    localparam op_mode_t    mode_reset   = cyclic_sync_position_mode;

    // Data path buffer depth.
    localparam int buf_depth = 2;

endpackage

// *** fb_skid_buffer.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Source and sink share clk; flush empties both entries at once.
// Notes: All outputs come straight from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module fb_skid_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = fb_state_pkg::buf_depth
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Filling side.
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side.
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    // The head and skid structure only serves exactly two entries.
    if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
        $error("fb_skid_buffer serves DEPTH 2 and WIDTH of at least 1 only.");
    end

    typedef struct packed {
        logic             in_ready;
        logic             head_valid;
        logic [WIDTH-1:0] head_data;
        logic             skid_valid;
        logic [WIDTH-1:0] skid_data;
    } buf_state_t;

    buf_state_t s;
    buf_state_t next_s;

    // The skid entry catches the word in flight when the sink stalls.
    always_comb begin
        next_s = s;
        if (flush) begin
            next_s.head_valid = 1'b0;
            next_s.skid_valid = 1'b0;
        end else begin
            if (s.head_valid && out_ready) begin
                next_s.head_valid = s.skid_valid;
                next_s.head_data  = s.skid_data;
                next_s.skid_valid = 1'b0;
            end
            if (in_valid && s.in_ready) begin
                if (!next_s.head_valid) begin
                    next_s.head_valid = 1'b1;
                    next_s.head_data  = in_data;
                end else begin
                    next_s.skid_valid = 1'b1;
                    next_s.skid_data  = in_data;
                end
            end
        end
        next_s.in_ready = !next_s.skid_valid;
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{in_ready: 1'b1, head_valid: 1'b0, head_data: '0,
                   skid_valid: 1'b0, skid_data: '0};
        end else begin
            s <= next_s;
        end
    end

    assign in_ready  = s.in_ready;
    assign out_valid = s.head_valid;
    assign out_data  = s.head_data;
endmodule
`default_nettype wire

// *** fieldbus_slave_state_control.sv ***
// Purpose: Slave-side communication state control for a fieldbus servo drive.
// Assumes: Master requests arrive from slave controller logic on clk.
// Notes: Data paths are gated by the communication state; stalls lose no word.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_state_control #(
    parameter int RX_WIDTH = 32,
    parameter int TX_WIDTH = 32
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst,
    // State requests from the master.
    input  wire logic                state_req_valid,
    input  wire logic [1:0]          state_req,
    output fb_state_pkg::comm_state_t comm_state,
    output logic                     skip_error,
    // Slave controller register accesses.
    input  wire logic                ctrl_reg_req,
    output logic                     ctrl_reg_ack,
    // Mailbox requests.
    input  wire logic                mbx_req_valid,
    input  wire logic [1:0]          mbx_proto,
    output logic                     mbx_ack,
    output logic                     mbx_reject,
    // Mapping selection over the mailbox.
    input  wire logic                map_wr_valid,
    input  wire logic                map_wr_tx,
    input  wire logic [15:0]         map_wr_index,
    output logic                     map_ack,
    output logic                     map_reject,
    output logic [15:0]              rx_map,
    output logic [15:0]              tx_map,
    // Operating mode commands.
    input  wire logic                mode_req_valid,
    input  wire logic [3:0]          mode_req,
    output fb_state_pkg::op_mode_t   op_mode,
    output logic                     mode_ack,
    output logic                     mode_reject,
    // Received process data from the master.
    input  wire logic                rx_valid,
    input  wire logic [RX_WIDTH-1:0] rx_data,
    output logic                     rx_ready,
    // Received process data toward the drive.
    output logic                     cmd_valid,
    output logic [RX_WIDTH-1:0]      cmd_data,
    input  wire logic                cmd_ready,
    // Transmit process data from the drive.
    input  wire logic                fb_valid,
    input  wire logic [TX_WIDTH-1:0] fb_data,
    output logic                     fb_ready,
    // Transmit process data toward the master.
    output logic                     tx_valid,
    output logic [TX_WIDTH-1:0]      tx_data,
    input  wire logic                tx_ready
);
    // Process data words need at least one bit each.
    if (RX_WIDTH < 1 || TX_WIDTH < 1) begin : g_bad_param
        $error("Process data widths must be at least one bit.");
    end

    typedef struct packed {
        fb_state_pkg::comm_state_t state;
        logic                      skip_err;
        logic                      reg_ack;
        logic                      mbx_ack;
        logic                      mbx_rej;
        logic                      map_ack;
        logic                      map_rej;
        logic [15:0]               rx_map;
        logic [15:0]               tx_map;
        fb_state_pkg::op_mode_t    mode;
        logic                      mode_ack;
        logic                      mode_rej;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    // Decoded permissions of the present state.
    logic mbx_open;
    logic tx_open;
    logic rx_open;
    logic map_open;
    logic up_step;
    logic is_up;
    logic rx_hit;
    logic tx_hit;
    logic [1:0] step_up;

    // Mailbox opens in mailbox-configuration and above; power-up has none.
    assign mbx_open = (s.state != fb_state_pkg::st_power_up);
    // Transmit data flows in inputs-only and full-exchange.
    assign tx_open  = (s.state == fb_state_pkg::st_inputs_only) ||
                      (s.state == fb_state_pkg::st_full_exchange);
    // Received output data is acted on in full-exchange only.
    assign rx_open  = (s.state == fb_state_pkg::st_full_exchange);
    // Mapping is set up before process data starts.
    assign map_open = (s.state == fb_state_pkg::st_mailbox_cfg);

    assign step_up = s.state + 2'h1;
    assign is_up   = (state_req > s.state);
    assign up_step = (state_req == step_up);

    // Offered maps: one variable and a fixed run in each direction.
    assign rx_hit = (map_wr_index == fb_state_pkg::rx_map_variable) ||
                    ((map_wr_index >= fb_state_pkg::rx_fixed_first) &&
                     (map_wr_index <= fb_state_pkg::rx_fixed_last));
    assign tx_hit = (map_wr_index == fb_state_pkg::tx_map_variable) ||
                    ((map_wr_index >= fb_state_pkg::tx_fixed_first) &&
                     (map_wr_index <= fb_state_pkg::tx_fixed_last));

    // Next-state logic for the state machine and request answers.
    always_comb begin
        next_s          = s;
        next_s.reg_ack  = 1'b0;
        next_s.mbx_ack  = 1'b0;
        next_s.mbx_rej  = 1'b0;
        next_s.map_ack  = 1'b0;
        next_s.map_rej  = 1'b0;
        next_s.mode_ack = 1'b0;
        next_s.mode_rej = 1'b0;

        // Controller registers answer in every state.
        if (ctrl_reg_req) begin
            next_s.reg_ack = 1'b1;
        end

        // State transitions; a request for the present state is a no-op.
        if (state_req_valid) begin
            if (is_up) begin
                if (up_step) begin
                    next_s.state    = fb_state_pkg::comm_state_t'(state_req);
                    next_s.skip_err = 1'b0;
                end else begin
                    // Skips are refused and flagged until the next good request.
                    next_s.skip_err = 1'b1;
                end
            end else if (state_req != s.state) begin
                // Any downward jump is honoured, including to power-up.
                next_s.state    = fb_state_pkg::comm_state_t'(state_req);
                next_s.skip_err = 1'b0;
            end
        end

        // Only the CAN application protocol is served on the mailbox.
        if (mbx_req_valid) begin
            if (mbx_open &&
                (mbx_proto == fb_state_pkg::can_app_over_fieldbus)) begin
                next_s.mbx_ack = 1'b1;
            end else begin
                next_s.mbx_rej = 1'b1;
            end
        end

        // Map selection checks range and the offered set.
        if (map_wr_valid) begin
            if (!map_open) begin
                next_s.map_rej = 1'b1;
            end else if (map_wr_tx) begin
                if ((map_wr_index >= fb_state_pkg::tx_map_lo) &&
                    (map_wr_index <= fb_state_pkg::tx_map_hi) && tx_hit) begin
                    next_s.tx_map  = map_wr_index;
                    next_s.map_ack = 1'b1;
                end else begin
                    next_s.map_rej = 1'b1;
                end
            end else begin
                if ((map_wr_index >= fb_state_pkg::rx_map_lo) &&
                    (map_wr_index <= fb_state_pkg::rx_map_hi) && rx_hit) begin
                    next_s.rx_map  = map_wr_index;
                    next_s.map_ack = 1'b1;
                end else begin
                    next_s.map_rej = 1'b1;
                end
            end
        end

        // A mode command is a received output, so it needs full-exchange.
        if (mode_req_valid) begin
            if (rx_open && (mode_req[3] == 1'b0)) begin
                next_s.mode     = fb_state_pkg::op_mode_t'(mode_req[2:0]);
                next_s.mode_ack = 1'b1;
            end else begin
                next_s.mode_rej = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{state:    fb_state_pkg::state_reset,
                   skip_err: 1'b0,
                   reg_ack:  1'b0,
                   mbx_ack:  1'b0,
                   mbx_rej:  1'b0,
                   map_ack:  1'b0,
                   map_rej:  1'b0,
                   rx_map:   fb_state_pkg::rx_map_reset,
                   tx_map:   fb_state_pkg::tx_map_reset,
                   mode:     fb_state_pkg::mode_reset,
                   mode_ack: 1'b0,
                   mode_rej: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Received words are taken while the buffer has room; outside full-exchange they are
    // discarded and the buffer is flushed so no stale command is acted on.
    fb_skid_buffer #(
        .WIDTH (RX_WIDTH),
        .DEPTH (fb_state_pkg::buf_depth)
    ) u_rx_buf (
        .clk       (clk),
        .rst       (rst),
        .flush     (!rx_open),
        .in_valid  (rx_valid && rx_open),
        .in_data   (rx_data),
        .in_ready  (rx_ready),
        .out_valid (cmd_valid),
        .out_data  (cmd_data),
        .out_ready (cmd_ready)
    );

    // Feedback words leave toward the master in inputs-only and above;
    // in lower states they are drained so the drive never stalls.
    fb_skid_buffer #(
        .WIDTH (TX_WIDTH),
        .DEPTH (fb_state_pkg::buf_depth)
    ) u_tx_buf (
        .clk       (clk),
        .rst       (rst),
        .flush     (!tx_open),
        .in_valid  (fb_valid && tx_open),
        .in_data   (fb_data),
        .in_ready  (fb_ready),
        .out_valid (tx_valid),
        .out_data  (tx_data),
        .out_ready (tx_ready)
    );

    // Outputs straight from the state register.
    assign comm_state   = s.state;
    assign skip_error   = s.skip_err;
    assign ctrl_reg_ack = s.reg_ack;
    assign mbx_ack      = s.mbx_ack;
    assign mbx_reject   = s.mbx_rej;
    assign map_ack      = s.map_ack;
    assign map_reject   = s.map_rej;
    assign rx_map       = s.rx_map;
    assign tx_map       = s.tx_map;
    assign op_mode      = s.mode;
    assign mode_ack     = s.mode_ack;
    assign mode_reject  = s.mode_rej;
endmodule
`default_nettype wire

// *** fieldbus_slave_state_control_assertions.sv ***
// Purpose: Concurrent checks on the ports of the slave state control.
// Assumes: One clock and a synchronous active-high reset.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module fb_state_checker #(
    parameter int RX_WIDTH = 32
) (
    // Clock and reset.
    input wire logic                      clk,
    input wire logic                      rst,
    // State requests.
    input wire logic                      state_req_valid,
    input wire logic [1:0]                state_req,
    input wire fb_state_pkg::comm_state_t comm_state,
    input wire logic                      skip_error,
    // Side requests and answers.
    input wire logic                      ctrl_reg_req,
    input wire logic                      ctrl_reg_ack,
    input wire logic                      mbx_req_valid,
    input wire logic [1:0]                mbx_proto,
    input wire logic                      mbx_ack,
    input wire logic                      mbx_reject,
    input wire logic                      mode_req_valid,
    input wire logic [3:0]                mode_req,
    input wire logic                      mode_ack,
    // Data paths.
    input wire logic                      rx_valid,
    input wire logic                      rx_ready,
    input wire logic [RX_WIDTH-1:0]       rx_data,
    input wire logic                      cmd_valid,
    input wire logic [RX_WIDTH-1:0]       cmd_data,
    input wire logic                      cmd_ready,
    input wire logic                      tx_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // State steps: one level up, any jump down, a skip is held and flagged.
    property p_skip_held;
        state_req_valid && ({1'b0, state_req} > {1'b0, comm_state} + 3'h1)
            |=> $stable(comm_state) && skip_error;
    endproperty
    a_skip_held: assert property (p_skip_held)
        else $error("skipping request not refused");
    property p_step_up;
        state_req_valid && ({1'b0, state_req} == {1'b0, comm_state} + 3'h1)
            |=> comm_state == $past(state_req) && !skip_error;
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("upward step not taken");
    property p_down; state_req_valid && state_req < comm_state |=> comm_state == $past(state_req);
    endproperty
    a_down: assert property (p_down)
        else $error("downward jump not taken");

    // Side requests answer on the next cycle.
    property p_ctrl; ctrl_reg_req |=> ctrl_reg_ack; endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("register access not served");
    property p_mbx_pu;
        mbx_req_valid && comm_state == fb_state_pkg::st_power_up |=> mbx_reject && !mbx_ack;
    endproperty
    a_mbx_pu: assert property (p_mbx_pu)
        else $error("mailbox served in power-up");
    property p_mbx_proto;
        mbx_req_valid && comm_state != fb_state_pkg::st_power_up
            |=> mbx_ack == ($past(mbx_proto) == 2'h0) && mbx_reject != mbx_ack;
    endproperty
    a_mbx_proto: assert property (p_mbx_proto)
        else $error("mailbox protocol filter wrong");
    property p_mode;
        mode_req_valid |=> mode_ack == ($past(comm_state) == fb_state_pkg::st_full_exchange
            && $past(mode_req) < 4'h8);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode answer wrong");

    // Process data gating and the buffer's keeping of words.
    property p_no_cmd;
        comm_state != fb_state_pkg::st_full_exchange
            && $past(comm_state) != fb_state_pkg::st_full_exchange |-> !cmd_valid;
    endproperty
    a_no_cmd: assert property (p_no_cmd)
        else $error("outputs acted on early");
    property p_no_tx;
        comm_state < fb_state_pkg::st_inputs_only
            && $past(comm_state) < fb_state_pkg::st_inputs_only |-> !tx_valid;
    endproperty
    a_no_tx: assert property (p_no_tx)
        else $error("transmit data before inputs-only");
    property p_rx_keep;
        rx_valid && rx_ready && comm_state == fb_state_pkg::st_full_exchange && !cmd_valid
            |=> cmd_valid && cmd_data == $past(rx_data);
    endproperty
    a_rx_keep: assert property (p_rx_keep)
        else $error("received word not passed on");
    property p_cmd_hold;
        cmd_valid && !cmd_ready && comm_state == fb_state_pkg::st_full_exchange
            && !state_req_valid |=> cmd_valid && $stable(cmd_data);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("stalled word lost");
endmodule

bind fieldbus_slave_state_control fb_state_checker #(.RX_WIDTH(RX_WIDTH)) u_chk (
    .clk, .rst, .state_req_valid, .state_req, .comm_state, .skip_error, .ctrl_reg_req,
    .ctrl_reg_ack, .mbx_req_valid, .mbx_proto, .mbx_ack, .mbx_reject, .mode_req_valid,
    .mode_req, .mode_ack, .rx_valid, .rx_ready, .rx_data, .cmd_valid, .cmd_data, .cmd_ready,
    .tx_valid
);
`default_nettype wire

// *** fb_master_model.sv ***
// Purpose: Behavioural master station on the far side of the data paths.
// Assumes: 32-bit words and one clock shared with the block.
// Notes: Offers an incrementing word sequence and sinks transmit words.
`timescale 1ns/1ps
`default_nettype none
module fb_master_model (
    // Clock, reset and bench controls.
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        send,
    input  wire logic        stall,
    // Output data toward the slave.
    output logic             rx_valid,
    output logic [31:0]      rx_data,
    input  wire logic        rx_ready,
    // Transmit data from the slave.
    input  wire logic        tx_valid,
    input  wire logic [31:0] tx_data,
    output logic             tx_ready,
    // Bookkeeping for the bench.
    output logic [31:0]      seq,
    output logic [31:0]      tx_last,
    output int               tx_count
);
    // A released line shows the inverse word, so stale data never looks valid.
    assign rx_data  = rx_valid ? seq : ~seq;
    assign tx_ready = !stall;

    // A word stays offered until taken; the sequence advances only on a take.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_valid <= 1'b0;
            seq <= 32'h0000_0100;
            tx_count <= 0;
            tx_last <= 32'h0;
        end else begin
            if (rx_valid && rx_ready) begin
                seq <= seq + 32'h1;
            end
            if (!rx_valid || rx_ready) begin
                rx_valid <= send;
            end
            if (tx_valid && tx_ready) begin
                tx_count <= tx_count + 1;
                tx_last <= tx_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** fieldbus_slave_state_control_tb.sv ***
// Purpose: Self-checking bench for the slave state control.
// Assumes: 200 MHz clock, reset held for 16 cycles.
// Notes: The bench plays the drive side; the master model plays the bus side.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_state_control_tb;
    localparam logic [4:0] RQ_ST = 5'h10, RQ_CTRL = 5'h08, RQ_MBX = 5'h04, RQ_MAP = 5'h02;
    localparam logic [4:0] RQ_MODE = 5'h01;
    // Bench-driven inputs.
    logic        clk, rst, state_req_valid, ctrl_reg_req, mbx_req_valid, map_wr_valid;
    logic        map_wr_tx, mode_req_valid, cmd_ready, fb_valid, send, stall;
    logic [1:0]  state_req, mbx_proto;
    logic [3:0]  mode_req;
    logic [15:0] map_wr_index;
    logic [31:0] fb_data;
    // Observed outputs.
    fb_state_pkg::comm_state_t comm_state;
    fb_state_pkg::op_mode_t    op_mode;
    logic        skip_error, ctrl_reg_ack, mbx_ack, mbx_reject, map_ack, map_reject;
    logic        mode_ack, mode_reject, rx_valid, rx_ready, cmd_valid, fb_ready, tx_valid;
    logic        tx_ready;
    logic [15:0] rx_map, tx_map;
    logic [31:0] rx_data, cmd_data, tx_data, seq, tx_last;
    int          tx_count, num_errors, n_tests;

    fieldbus_slave_state_control dut (
        .clk, .rst, .state_req_valid, .state_req, .comm_state, .skip_error, .ctrl_reg_req,
        .ctrl_reg_ack, .mbx_req_valid, .mbx_proto, .mbx_ack, .mbx_reject, .map_wr_valid,
        .map_wr_tx, .map_wr_index, .map_ack, .map_reject, .rx_map, .tx_map, .mode_req_valid,
        .mode_req, .op_mode, .mode_ack, .mode_reject, .rx_valid, .rx_data, .rx_ready,
        .cmd_valid, .cmd_data, .cmd_ready, .fb_valid, .fb_data, .fb_ready, .tx_valid,
        .tx_data, .tx_ready
    );
    fb_master_model u_master (
        .clk, .rst, .send, .stall, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
        .tx_ready, .seq, .tx_last, .tx_count
    );

    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count a comparison and report a mismatch at once.
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // Verdict and end of the run.
    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One strobe held for one edge; the answers are settled on return.
    task automatic fire(input logic [4:0] m, input logic [15:0] v);
        @(posedge clk);
        {state_req_valid, ctrl_reg_req, mbx_req_valid, map_wr_valid, mode_req_valid} <= m;
        {state_req, mbx_proto} <= {2{v[1:0]}};
        mode_req <= v[3:0];
        map_wr_index <= v;
        map_wr_tx <= v[11];
        @(posedge clk);
        {state_req_valid, ctrl_reg_req, mbx_req_valid, map_wr_valid, mode_req_valid} <= 5'h0;
        #1;
    endtask

    task automatic go(input logic [1:0] s, input logic [1:0] exp, input logic err);
        fire(RQ_ST, {14'h0, s});
        chk(comm_state === exp && skip_error === err, "state step");
    endtask

    // Power-up: register access only, skips refused.
    task automatic t_power_up();
        chk(comm_state === fb_state_pkg::st_power_up, "reset state");
        chk(rx_map === 16'h1600 && tx_map === 16'h1a00 && op_mode === 3'h5, "reset");
        fire(RQ_CTRL, 16'h0);
        chk(ctrl_reg_ack === 1'b1, "register access");
        fire(RQ_MBX, 16'h0);
        chk(mbx_reject === 1'b1 && mbx_ack === 1'b0, "mailbox in power-up");
        go(2'h2, 2'h0, 1'b1);
        go(2'h1, 2'h1, 1'b0);
    endtask

    // Mailbox state: protocol filter, map choice, no process data.
    task automatic t_mailbox();
        logic [15:0] idx [10] = '{16'h1600, 16'h1701, 16'h1705, 16'h1700, 16'h1706,
                                  16'h1a00, 16'h1b01, 16'h1b04, 16'h1b05, 16'h1a01};
        logic [15:0] er = 16'h1600, et = 16'h1a00;
        logic        ok;
        for (int p = 0; p < 4; p++) begin
            fire(RQ_MBX, 16'(p));
            chk(mbx_ack === (p == 0) && mbx_reject === (p != 0), "mailbox protocol");
        end
        for (int i = 0; i < 10; i++) begin
            ok = (i % 5) < 3;
            er = (ok && i < 5) ? idx[i] : er;
            et = (ok && i >= 5) ? idx[i] : et;
            fire(RQ_MAP, idx[i]);
            chk(map_ack === ok && map_reject === !ok, "map answer");
            chk(rx_map === er && tx_map === et, "map value");
        end
        go(2'h3, 2'h1, 1'b1);
        @(posedge clk);
        {send, fb_valid} <= 2'h3;
        repeat (6) begin
            @(posedge clk);
            #1;
            chk(cmd_valid === 1'b0 && tx_valid === 1'b0, "data in mailbox");
        end
        @(posedge clk);
        {send, fb_valid} <= 2'h0;
        go(2'h2, 2'h2, 1'b0);
    endtask

    // Inputs-only: transmit words flow, held while the master stalls.
    task automatic t_inputs_only();
        int n;
        n = tx_count;
        @(posedge clk);
        fb_valid <= 1'b1;
        fb_data <= 32'hc0de_0001;
        stall <= 1'b1;
        @(posedge clk);
        fb_valid <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(tx_valid === 1'b1 && tx_data === 32'hc0de_0001, "transmit held");
        @(posedge clk);
        stall <= 1'b0;
        for (int i = 0; i < 20 && tx_count == n; i++) @(posedge clk);
        chk(tx_count == n + 1 && tx_last === 32'hc0de_0001, "transmit word");
        if (tx_count == n) end_sim();
    endtask

    // Full exchange: fill and drain, modes, then a jump down.
    task automatic t_full();
        logic [31:0] base;
        int          n;
        @(posedge clk);
        send <= 1'b1;
        cmd_ready <= 1'b0;
        go(2'h3, 2'h3, 1'b0);
        base = seq;
        repeat (6) @(posedge clk);
        #1;
        chk(rx_ready === 1'b0 && cmd_valid === 1'b1 && cmd_data === base, "buffer full");
        @(posedge clk);
        send <= 1'b0;
        cmd_ready <= 1'b1;
        n = 0;
        for (int i = 0; i < 10; i++) begin
            #1;
            if (cmd_valid === 1'b1) begin
                chk(cmd_data === base + 32'(n), "word order");
                n++;
            end
            @(posedge clk);
        end
        chk(n == 3 && seq == base + 32'h3, "word lost");
        {send, fb_valid, stall, cmd_ready} <= 4'he;
        for (int m = 0; m < 9; m++) begin
            fire(RQ_MODE, 16'(m));
            chk(mode_ack === (m < 8) && mode_reject === (m >= 8), "mode answer");
            chk(m >= 8 || op_mode === 3'(m), "mode value");
        end
        fire(RQ_MBX, 16'h0);
        chk(mbx_ack === 1'b1, "mailbox in full");
        go(2'h0, 2'h0, 1'b0);
        @(posedge clk);
        #1;
        chk(cmd_valid === 1'b0 && tx_valid === 1'b0 && fb_ready === 1'b1, "paths closed");
    endtask

    // Main sequence.
    initial begin
        {rst, state_req_valid, ctrl_reg_req, mbx_req_valid, map_wr_valid} = 5'h10;
        {map_wr_tx, mode_req_valid, fb_valid, send, stall} = 5'h0;
        cmd_ready = 1'b1;
        {state_req, mbx_proto, mode_req, map_wr_index, fb_data} = 56'h0;
        {num_errors, n_tests} = 64'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_power_up();
        t_mailbox();
        t_inputs_only();
        t_full();
        end_sim();
    end
endmodule
`default_nettype wire
